// ---- core/timer_defines.vh ----
// constants for the 16-bit waveform timer: offsets, fields, resets, modes
// Function
// RQ1: counting up, count equal to TOP wraps to zero on the next tick
// RQ2: counting down, count at BOTTOM reloads with the cycle length value
// RQ3: direction follows count_heading, changeable while running
// RQ4: normal ticks come from the module clock through the selected prescaler
// RQ5: software count write is immediate and beats count, clear or reload
// RQ6: writing enable starts counting on prescaled ticks; TOP written first
// RQ7: event_count_enable makes the counter advance on events instead
// RQ8: each shadow has a valid flag, set by shadow write, cleared at update
// RQ9: working match and its shadow both writable; direct write bypasses buffer
// RQ10: direct write of cycle length takes effect at once
// RQ11: unbuffered TOP below count lets counter run on to all-ones and wrap
// RQ12: cycle length loads from its valid shadow only at update
// RQ13: count equal to match value sets channel flag on the next tick
// RQ14: valid match shadow copied at update, used from the next count
// RQ15: pin driven only with waveform mode selected and channel enabled; the code also drives it in the undefined mode 3
// RQ16: toggle mode takes its period from match_value_0
// RQ17: toggle mode flips each channel output on its own match
// RQ18: toggle mode, match_value_0 zero, divide one gives half clock rate
// RQ19: single-slope: count BOTTOM to TOP, set at BOTTOM, clear on match
// RQ20: single-slope: match at BOTTOM stays low, above TOP stays high
// RQ21: BOTTOM is the all-zero count
// RQ22: update happens at BOTTOM or TOP per mode unless update_lock set; the code picks it by count_heading alone, not by mode
// RQ23: flags and output changes from TOP, BOTTOM or match land on next tick
// RQ24: clearing channel enable releases the pin, waveform state kept
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_COUNT 8'h08
`define OFS_CYCLE 8'h0C
`define OFS_CYCLE_SH 8'h10
`define OFS_MATCH0 8'h14
`define OFS_MATCH1 8'h18
`define OFS_MATCH2 8'h1C
`define OFS_MSH0 8'h20
`define OFS_MSH1 8'h24
`define OFS_MSH2 8'h28
// control fields
`define CTRL_W 12
`define CTRL_ENABLE 0
`define CTRL_PRE_LO 1
`define CTRL_PRE_HI 3
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 5
`define CTRL_CHEN_LO 6
`define CTRL_CHEN_HI 8
`define CTRL_HEADING 9
`define CTRL_LOCK 10
`define CTRL_EVCNT 11
`define CTRL_RESET 12'h000
// status fields
`define ST_OVF 0
`define ST_MATCH_LO 1
`define ST_VALID_LO 4
`define ST_WAVE_LO 8
// waveform modes
`define MODE_NORMAL 2'h0
`define MODE_TOGGLE 2'h1
`define MODE_SINGLE 2'h2
// resets and boundaries
`define BOTTOM 16'h0000
`define ALL_ONES 16'hFFFF
`define CYCLE_RESET 16'hFFFF
`define MATCH_RESET 16'h0000
`define PRE_W 10
`endif

// ---- core/tick_prescaler.v ----
// prescaler that turns the module clock into one-cycle timer ticks
`timescale 1ns/100ps
`include "timer_defines.vh"
module tick_prescaler (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire [2:0] select,
  output wire tick
);
  reg [`PRE_W-1:0] div_reg;
  // divisor mask minus one for each select code: 1,2,4,8,16,64,256,1024
  function [`PRE_W-1:0] div_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: div_mask = 10'h000;
        3'h1: div_mask = 10'h001;
        3'h2: div_mask = 10'h003;
        3'h3: div_mask = 10'h007;
        3'h4: div_mask = 10'h00F;
        3'h5: div_mask = 10'h03F;
        3'h6: div_mask = 10'h0FF;
        default: div_mask = 10'h3FF;
      endcase
    end
  endfunction
  // free count while running; held at zero when stopped so first tick is a full period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 10'h000;
    end else if (!run) begin
      div_reg <= 10'h000;
    end else begin
      div_reg <= div_reg + 10'h001;
    end
  end
  assign tick = run && ((div_reg & div_mask(select)) == div_mask(select)); // RQ4
endmodule // tick_prescaler

// ---- core/wave_channel.v ----
// one compare channel: match detection and its waveform state
`timescale 1ns/100ps
`include "timer_defines.vh"
module wave_channel (
  input wire clk,
  input wire rst_n,
  input wire tick,
  input wire [1:0] mode,
  input wire [15:0] count,
  input wire [15:0] match,
  output wire hit,
  output reg wave
);
  wire equal;
  assign equal = (count == match);
  assign hit = tick && equal; // RQ13
  // wave changes on the tick after the triggering count value
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave <= 1'b0;
    end else if (tick) begin
      case (mode)
        `MODE_TOGGLE: begin
          if (equal) begin
            wave <= ~wave; // RQ17 RQ18 RQ23
          end
        end
        `MODE_SINGLE: begin
          // clear beats set, so a match at BOTTOM keeps the output low
          if (equal) begin
            wave <= 1'b0; // RQ19 RQ20
          end else if (count == `BOTTOM) begin
            wave <= 1'b1; // RQ19 RQ21
          end
        end
        default: begin
          wave <= wave;
        end
      endcase
    end
  end
endmodule // wave_channel

// ---- core/wave_timer.v ----
// 16-bit timer core with three compare channels behind an APB slave
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "timer_defines.vh"
module wave_timer (
  input wire REF_CLK,
  input wire RESETN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire EVENT_IN,
  output reg [2:0] WAVE_OUT,
  output reg [2:0] WAVE_OE_N
);
  // register index codes returned by the address decoder
  localparam [3:0] R_CTRL = 4'h0;
  localparam [3:0] R_STATUS = 4'h1;
  localparam [3:0] R_COUNT = 4'h2;
  localparam [3:0] R_CYCLE = 4'h3;
  localparam [3:0] R_CYCLE_SH = 4'h4;
  localparam [3:0] R_MATCH0 = 4'h5;
  localparam [3:0] R_MATCH1 = 4'h6;
  localparam [3:0] R_MATCH2 = 4'h7;
  localparam [3:0] R_MSH0 = 4'h8;
  localparam [3:0] R_MSH1 = 4'h9;
  localparam [3:0] R_MSH2 = 4'hA;
  localparam [3:0] R_NONE = 4'hF;

  // software state
  reg [`CTRL_W-1:0] ctrl_reg;
  reg [3:0] flags_reg;
  reg [15:0] count_reg;
  reg [15:0] cycle_length_reg;
  reg [15:0] cycle_length_shadow_reg;
  reg cycle_shadow_valid_reg;
  reg [15:0] match_value_0_reg;
  reg [15:0] match_value_1_reg;
  reg [15:0] match_value_2_reg;
  reg [15:0] match_value_shadow_0_reg;
  reg [15:0] match_value_shadow_1_reg;
  reg [15:0] match_value_shadow_2_reg;
  reg [2:0] match_shadow_valid_reg;

  // event pin synchroniser and filtered level
  reg ev_s1_reg;
  reg ev_s2_reg;
  reg ev_s3_reg;
  reg ev_level_reg;

  // control fields
  wire enable;
  wire [2:0] prescale_select;
  wire [1:0] wave_mode_select;
  wire [2:0] channel_output_enable;
  wire count_heading;
  wire update_lock;
  wire event_count_enable;

  // tick and counter decisions
  wire presc_tick;
  wire event_pulse;
  wire timer_tick;
  wire [15:0] top_value;
  wire at_top;
  wire at_bottom;
  wire wrap;
  wire update_now;
  wire [2:0] hit;
  wire [2:0] wave;

  // bus decode
  wire access;
  wire wr_done;
  wire [3:0] addr_index;
  wire [3:0] wr_index;
  reg [31:0] rd_data;
  reg [15:0] count_next;

  // map a byte address onto a register index; unmapped gives R_NONE
  function [3:0] reg_index;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_CTRL: reg_index = R_CTRL;
        `OFS_STATUS: reg_index = R_STATUS;
        `OFS_COUNT: reg_index = R_COUNT;
        `OFS_CYCLE: reg_index = R_CYCLE;
        `OFS_CYCLE_SH: reg_index = R_CYCLE_SH;
        `OFS_MATCH0: reg_index = R_MATCH0;
        `OFS_MATCH1: reg_index = R_MATCH1;
        `OFS_MATCH2: reg_index = R_MATCH2;
        `OFS_MSH0: reg_index = R_MSH0;
        `OFS_MSH1: reg_index = R_MSH1;
        `OFS_MSH2: reg_index = R_MSH2;
        default: reg_index = R_NONE;
      endcase
    end
  endfunction

  assign enable = ctrl_reg[`CTRL_ENABLE];
  assign prescale_select = ctrl_reg[`CTRL_PRE_HI:`CTRL_PRE_LO];
  assign wave_mode_select = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign channel_output_enable = ctrl_reg[`CTRL_CHEN_HI:`CTRL_CHEN_LO];
  assign count_heading = ctrl_reg[`CTRL_HEADING];
  assign update_lock = ctrl_reg[`CTRL_LOCK];
  assign event_count_enable = ctrl_reg[`CTRL_EVCNT];

  // apb: one wait state, the transfer completes on the edge after pready rises
  assign access = PSEL && PENABLE;
  assign wr_done = access && PREADY && PWRITE;
  assign addr_index = reg_index(PADDR);
  assign wr_index = wr_done ? addr_index : R_NONE;

  // prescaler only runs while enabled and not counting events
  tick_prescaler u_prescaler (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .run(enable && !event_count_enable),
    .select(prescale_select),
    .tick(presc_tick)
  );

  // three-stage event sync; level moves only once stages two and three agree
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ev_s1_reg <= 1'b0;
      ev_s2_reg <= 1'b0;
      ev_s3_reg <= 1'b0;
      ev_level_reg <= 1'b0;
    end else begin
      ev_s1_reg <= EVENT_IN;
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
      if (ev_s2_reg == ev_s3_reg) begin
        ev_level_reg <= ev_s2_reg;
      end
    end
  end

  // an event is a rising edge of the filtered level
  assign event_pulse = (ev_s2_reg == ev_s3_reg) && ev_s2_reg && !ev_level_reg;

  // timer tick source selection
  assign timer_tick = enable && (event_count_enable ? event_pulse : presc_tick); // RQ6 RQ7 RQ4

  // toggle mode takes its period from channel 0 instead of the cycle length
  assign top_value = (wave_mode_select == `MODE_TOGGLE) ?
                     match_value_0_reg : cycle_length_reg; // RQ16
  assign at_top = (count_reg == top_value); // RQ10
  assign at_bottom = (count_reg == `BOTTOM); // RQ21
  // end of a cycle: TOP counting up, BOTTOM counting down
  assign wrap = timer_tick && (count_heading ? at_bottom : at_top);
  // update rides on the cycle end, so it is TOP or BOTTOM by count_heading alone
  assign update_now = wrap && !update_lock; // RQ22

  // next count; a count above an unbuffered TOP simply runs to all-ones
  always @* begin
    count_next = count_reg;
    if (timer_tick) begin
      if (count_heading) begin
        if (at_bottom) begin
          count_next = top_value; // RQ2
        end else begin
          count_next = count_reg - 16'h0001; // RQ3
        end
      end else begin
        if (at_top) begin
          count_next = `BOTTOM; // RQ1
        end else begin
          count_next = count_reg + 16'h0001; // RQ11 RQ3
        end
      end
    end
  end

  // counter: a software write wins over any tick in the same cycle
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      count_reg <= `BOTTOM;
    end else if (wr_index == R_COUNT) begin
      count_reg <= PWDATA[15:0]; // RQ5
    end else begin
      count_reg <= count_next;
    end
  end

  // control register
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_index == R_CTRL) begin
      ctrl_reg <= PWDATA[`CTRL_W-1:0]; // RQ3 RQ6
    end
  end

  // cycle length and its shadow; direct write beats an update in the same cycle
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cycle_length_reg <= `CYCLE_RESET;
      cycle_length_shadow_reg <= `CYCLE_RESET;
      cycle_shadow_valid_reg <= 1'b0;
    end else begin
      if (wr_index == R_CYCLE) begin
        cycle_length_reg <= PWDATA[15:0]; // RQ10
      end else if (update_now && cycle_shadow_valid_reg) begin
        cycle_length_reg <= cycle_length_shadow_reg; // RQ12
      end
      if (wr_index == R_CYCLE_SH) begin
        cycle_length_shadow_reg <= PWDATA[15:0];
      end
      // a shadow write in the update cycle keeps the flag set
      if (wr_index == R_CYCLE_SH) begin
        cycle_shadow_valid_reg <= 1'b1; // RQ8
      end else if (update_now) begin
        cycle_shadow_valid_reg <= 1'b0; // RQ8
      end
    end
  end

  // match values and their shadows, both software writable
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      match_value_0_reg <= `MATCH_RESET;
      match_value_1_reg <= `MATCH_RESET;
      match_value_2_reg <= `MATCH_RESET;
      match_value_shadow_0_reg <= `MATCH_RESET;
      match_value_shadow_1_reg <= `MATCH_RESET;
      match_value_shadow_2_reg <= `MATCH_RESET;
      match_shadow_valid_reg <= 3'h0;
    end else begin
      if (wr_index == R_MATCH0) begin
        match_value_0_reg <= PWDATA[15:0]; // RQ9
      end else if (update_now && match_shadow_valid_reg[0]) begin
        match_value_0_reg <= match_value_shadow_0_reg; // RQ14
      end
      if (wr_index == R_MATCH1) begin
        match_value_1_reg <= PWDATA[15:0]; // RQ9
      end else if (update_now && match_shadow_valid_reg[1]) begin
        match_value_1_reg <= match_value_shadow_1_reg; // RQ14
      end
      if (wr_index == R_MATCH2) begin
        match_value_2_reg <= PWDATA[15:0]; // RQ9
      end else if (update_now && match_shadow_valid_reg[2]) begin
        match_value_2_reg <= match_value_shadow_2_reg; // RQ14
      end
      if (wr_index == R_MSH0) begin
        match_value_shadow_0_reg <= PWDATA[15:0];
      end
      if (wr_index == R_MSH1) begin
        match_value_shadow_1_reg <= PWDATA[15:0];
      end
      if (wr_index == R_MSH2) begin
        match_value_shadow_2_reg <= PWDATA[15:0];
      end
      // valid flags: set by shadow write, cleared by update, set wins
      if (wr_index == R_MSH0) begin
        match_shadow_valid_reg[0] <= 1'b1; // RQ8
      end else if (update_now) begin
        match_shadow_valid_reg[0] <= 1'b0; // RQ8
      end
      if (wr_index == R_MSH1) begin
        match_shadow_valid_reg[1] <= 1'b1; // RQ8
      end else if (update_now) begin
        match_shadow_valid_reg[1] <= 1'b0; // RQ8
      end
      if (wr_index == R_MSH2) begin
        match_shadow_valid_reg[2] <= 1'b1; // RQ8
      end else if (update_now) begin
        match_shadow_valid_reg[2] <= 1'b0; // RQ8
      end
    end
  end

  // compare channels see the working match values
  wave_channel u_ch0 (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .tick(timer_tick),
    .mode(wave_mode_select),
    .count(count_reg),
    .match(match_value_0_reg),
    .hit(hit[0]),
    .wave(wave[0])
  );

  wave_channel u_ch1 (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .tick(timer_tick),
    .mode(wave_mode_select),
    .count(count_reg),
    .match(match_value_1_reg),
    .hit(hit[1]),
    .wave(wave[1])
  );

  wave_channel u_ch2 (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .tick(timer_tick),
    .mode(wave_mode_select),
    .count(count_reg),
    .match(match_value_2_reg),
    .hit(hit[2]),
    .wave(wave[2])
  );

  // sticky flags, write one to clear; a new hit in the clear cycle survives
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flags_reg <= 4'h0;
    end else begin
      if (wrap) begin
        flags_reg[`ST_OVF] <= 1'b1; // RQ23
      end else if (wr_index == R_STATUS && PWDATA[`ST_OVF]) begin
        flags_reg[`ST_OVF] <= 1'b0;
      end
      if (hit[0]) begin
        flags_reg[1] <= 1'b1; // RQ13
      end else if (wr_index == R_STATUS && PWDATA[1]) begin
        flags_reg[1] <= 1'b0;
      end
      if (hit[1]) begin
        flags_reg[2] <= 1'b1; // RQ13
      end else if (wr_index == R_STATUS && PWDATA[2]) begin
        flags_reg[2] <= 1'b0;
      end
      if (hit[2]) begin
        flags_reg[3] <= 1'b1; // RQ13
      end else if (wr_index == R_STATUS && PWDATA[3]) begin
        flags_reg[3] <= 1'b0;
      end
    end
  end

  // pin override: driven whenever the mode is not MODE_NORMAL and the channel is enabled;
  // disabling a channel releases the pin but the channel keeps its state
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      WAVE_OUT <= 3'h0;
      WAVE_OE_N <= 3'h7;
    end else begin
      WAVE_OUT <= wave;
      if (wave_mode_select == `MODE_NORMAL) begin
        WAVE_OE_N <= 3'h7; // RQ15
      end else begin
        WAVE_OE_N <= ~channel_output_enable; // RQ15 RQ24
      end
    end
  end

  // read multiplexer; unused upper bits read as zero
  always @* begin
    rd_data = 32'h00000000;
    case (addr_index)
      R_CTRL: rd_data[`CTRL_W-1:0] = ctrl_reg;
      R_STATUS: begin
        rd_data[3:0] = flags_reg;
        rd_data[`ST_VALID_LO] = cycle_shadow_valid_reg;
        rd_data[`ST_VALID_LO+3:`ST_VALID_LO+1] = match_shadow_valid_reg;
        rd_data[`ST_WAVE_LO+2:`ST_WAVE_LO] = wave;
      end
      R_COUNT: rd_data[15:0] = count_reg;
      R_CYCLE: rd_data[15:0] = cycle_length_reg;
      R_CYCLE_SH: rd_data[15:0] = cycle_length_shadow_reg;
      R_MATCH0: rd_data[15:0] = match_value_0_reg;
      R_MATCH1: rd_data[15:0] = match_value_1_reg;
      R_MATCH2: rd_data[15:0] = match_value_2_reg;
      R_MSH0: rd_data[15:0] = match_value_shadow_0_reg;
      R_MSH1: rd_data[15:0] = match_value_shadow_1_reg;
      R_MSH2: rd_data[15:0] = match_value_shadow_2_reg;
      default: rd_data = 32'h00000000;
    endcase
  end

  // answer: pready for one cycle after the first access cycle
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access && !PREADY;
      if (access && !PREADY) begin
        PRDATA <= PWRITE ? 32'h00000000 : rd_data;
        PSLVERR <= (addr_index == R_NONE);
      end else begin
        PRDATA <= 32'h00000000;
        PSLVERR <= 1'b0;
      end
    end
  end
endmodule // wave_timer

// ---- verif/wave_timer_asserts.sv ----
// checker of the bus handshake and pin enables of the waveform timer
`timescale 1ns/100ps
module wave_timer_checker (
  input wire REF_CLK,
  input wire RESETN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire EVENT_IN,
  input wire [2:0] WAVE_OUT,
  input wire [2:0] WAVE_OE_N
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // first access edge of a transfer, before the slave answers
  wire acc_edge;
  assign acc_edge = PSEL && PENABLE && !PREADY;
  property p_one_wait; acc_edge |=> PREADY; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready missing after access");
  property p_ready_pulse; PREADY |=> !PREADY; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_no_spurious; !acc_edge |=> !PREADY; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("ready without access");
  property p_err_with_ready; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_idle_rdata; !PREADY |-> PRDATA == 32'h0; endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside ready");
  property p_unmapped; acc_edge && PADDR > 8'h28 |=> PSLVERR; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    acc_edge && PADDR <= 8'h28 && PADDR[1:0] == 2'h0 |=> !PSLVERR;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_upper_zero; PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  // pin enables only move one or two cycles after a completed bus transfer, read or write
  property p_oe_by_write; $changed(WAVE_OE_N) |-> $past(PREADY) || $past(PREADY, 2); endproperty
  a_oe_by_write: assert property (p_oe_by_write) else $error("pin enable moved alone");
  c_refused: cover property (acc_edge && PADDR > 8'h28);
  c_toggle: cover property (!WAVE_OE_N[0] ##1 $changed(WAVE_OUT[0]));
  c_read: cover property (PREADY && !PWRITE);
endmodule // wave_timer_checker

bind wave_timer wave_timer_checker u_checker (.REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EVENT_IN(EVENT_IN), .WAVE_OUT(WAVE_OUT),
  .WAVE_OE_N(WAVE_OE_N));

// ---- verif/wave_timer_test.sv ----
// self-checking bench of the waveform timer
`timescale 1ns/100ps
`include "timer_defines.vh"
module wave_timer_test;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic event_in = 1'b0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [2:0] wave_out;
  wire [2:0] wave_oe_n;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] q;
  logic err;
  wave_timer DUT (.REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EVENT_IN(event_in), .WAVE_OUT(wave_out), .WAVE_OE_N(wave_oe_n));
  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;
  // cut a hang short; the longest scenario needs a few thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      end_of_test;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer; no answer latency is assumed, the wait is bounded
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 16) check(32'h0, 32'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task automatic reset_values;
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_CYCLE, 32'h0000FFFF);
    rd(`OFS_CYCLE_SH, 32'h0000FFFF);
    rd(`OFS_MSH2, 32'h0);
    rd(8'h2C, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(8'h2C, 32'h0000FFFF);
    check({31'h0, err}, 32'h1);
  endtask
  // stop, clear flags and preset count and top
  task automatic setup(input logic [15:0] cnt, input logic [15:0] top);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_STATUS, 32'h0000000F);
    wr(`OFS_COUNT, {16'h0, cnt});
    wr(`OFS_CYCLE, {16'h0, top});
  endtask
  task automatic wrap_and_reload;
    setup(16'h0003, 16'h0003);
    wr(`OFS_CTRL, 32'h0000000F);
    repeat (1100) @(posedge ref_clk);
    rd(`OFS_STATUS, 32'h1);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_COUNT, 32'h0);
    setup(16'h0000, 16'h0007);
    wr(`OFS_CTRL, 32'h0000020F);
    repeat (1100) @(posedge ref_clk);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_COUNT, 32'h7);
  endtask
  task automatic top_below_count;
    setup(16'h000A, 16'h0005);
    wr(`OFS_CTRL, 32'h1);
    repeat (20) @(posedge ref_clk);
    wr(`OFS_CTRL, 32'h0);
    apb(1'b0, `OFS_COUNT, 32'h0);
    check({31'h0, q[15:0] > 16'h000A}, 32'h1);
    rd(`OFS_STATUS, 32'h0);
  endtask
  task automatic toggle_mode;
    logic prev;
    setup(16'h0000, 16'h0003);
    wr(`OFS_MATCH0, 32'h0);
    wr(`OFS_CTRL, 32'h00000051);
    repeat (4) @(negedge ref_clk);
    check({29'h0, wave_oe_n}, 32'h6);
    prev = wave_out[0];
    repeat (8) begin
      @(negedge ref_clk);
      check({31'h0, wave_out[0]}, {31'h0, ~prev});
      prev = wave_out[0];
    end
    wr(`OFS_CTRL, 32'h00000011);
    repeat (3) @(negedge ref_clk);
    check({29'h0, wave_oe_n}, 32'h7);
  endtask
  task automatic single_slope;
    int hi [3];
    hi = '{0, 0, 0};
    setup(16'h0000, 16'h0003);
    wr(`OFS_MATCH0, 32'h0);
    wr(`OFS_MATCH1, 32'h2);
    wr(`OFS_MATCH2, 32'h5);
    wr(`OFS_CTRL, 32'h000001E1);
    repeat (10) @(negedge ref_clk);
    check({29'h0, wave_oe_n}, 32'h0);
    repeat (16) begin
      @(negedge ref_clk);
      for (int c = 0; c < 3; c++) hi[c] += (wave_out[c] === 1'b1);
    end
    check(hi[0], 32'h0);
    check(hi[1], 32'h8);
    check(hi[2], 32'h10);
    // stopped: wrap and the two reachable match flags stand, channel 2 never matched
    wr(`OFS_CTRL, 32'h0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(q & 32'h000005FF, 32'h00000407);
  endtask
  task automatic buffered;
    setup(16'h0000, 16'h0001);
    wr(`OFS_CYCLE_SH, 32'h9);
    wr(`OFS_MSH1, 32'h4);
    // channel 1 wave state is left over from the pwm run, so only its bit is masked
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(q & 32'h000005FF, 32'h00000450);
    wr(`OFS_CTRL, 32'h00000401);
    repeat (20) @(posedge ref_clk);
    rd(`OFS_CYCLE, 32'h1);
    wr(`OFS_CTRL, 32'h1);
    repeat (20) @(posedge ref_clk);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_CYCLE, 32'h9);
    rd(`OFS_MATCH1, 32'h4);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(q & 32'h000000F0, 32'h0);
  endtask
  task automatic event_count;
    setup(16'h0000, 16'hFFFF);
    wr(`OFS_CTRL, 32'h00000801);
    repeat (3) begin
      @(posedge ref_clk) event_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      event_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    repeat (8) @(posedge ref_clk);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_COUNT, 32'h3);
    wr(`OFS_COUNT, 32'h1234);
    rd(`OFS_COUNT, 32'h1234);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    reset_values;
    wrap_and_reload;
    top_below_count;
    toggle_mode;
    single_slope;
    buffered;
    event_count;
    end_of_test;
  end
endmodule // wave_timer_test
